/* rtm_pkg.sv */
/*
 * Shared constants and types for the reload timer with comparator capture.
 * Assumes an 8-bit register port with a 3-bit word address and a single 100 MHz clock.
 */
package rtm_pkg;

   // register offsets
   localparam logic [2:0] OFS_CTRL      = 3'h0;
   localparam logic [2:0] OFS_RELOAD_LO = 3'h1;
   localparam logic [2:0] OFS_RELOAD_HI = 3'h2;
   localparam logic [2:0] OFS_COUNT_LO  = 3'h3;
   localparam logic [2:0] OFS_COUNT_HI  = 3'h4;
   localparam logic [2:0] OFS_CLK_CTRL  = 3'h5;
   localparam logic [2:0] OFS_INT_EN    = 3'h6;
   localparam logic [2:0] OFS_STATUS    = 3'h7;

   // field positions in the clock control, interrupt enable and status registers
   localparam int CLK_LOW_SEL_BIT  = 0;
   localparam int CLK_HIGH_SEL_BIT = 1;
   localparam int TIMER_IE_BIT     = 7;
   localparam int SYNC_BUSY_BIT    = 0;

   // reset values
   localparam logic [7:0] CTRL_RESET   = 8'h00;
   localparam logic [7:0] BYTE_RESET   = 8'h00;
   localparam logic [1:0] CLKSEL_RESET = 2'h0;

   // counting constants
   localparam logic [7:0]  BYTE_MAX   = 8'hFF;
   localparam logic [15:0] WORD_MAX   = 16'hFFFF;
   localparam logic [3:0]  SYS_DIV    = 4'hC;
   localparam logic [1:0]  EXT_HALF   = 2'h3;
   localparam logic [1:0]  SYNC_TICKS = 2'h3;

   // control register layout, bit 7 down to bit 0
   typedef struct packed {
      logic hi_flag;
      logic lo_flag;
      logic lo_ie;
      logic cap_en;
      logic split;
      logic run;
      logic unused;
      logic ext_sel;
   } rtm_ctrl_t;

   typedef enum logic [1:0] {
      SYNC_IDLE = 2'b01,
      SYNC_BUSY = 2'b10
   } rtm_sync_t;

endpackage

/* rtm_prescale.sv */
/*
 * Clock prescaler: system clock divided by 12 and external oscillator divided by 8,
 * both as one-cycle enable pulses. Assumes ext_clk is sampled on ref_clk.
 */
`timescale 1ns/1ps
module rtm_prescale
(
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_b,
   // sources
   input  wire logic ext_clk,
   input  wire logic suspend,
   // tick enables
   output logic      tick_sys12,
   output logic      tick_ext
);

   logic [3:0] div_cnt;
   logic [3:0] next_div_cnt;
   logic       ext_q;
   logic [1:0] ext_cnt;
   logic [1:0] next_ext_cnt;
   logic       ext_div;
   logic       next_ext_div;
   logic       sync1;
   logic       sync2;
   logic       sync3;
   logic       ext_rise;
   logic       direct_tick;

   assign ext_rise = ext_clk & ~ext_q;

   always_comb
   begin
      next_div_cnt = (div_cnt == rtm_pkg::SYS_DIV - 4'h1) ? 4'h0 : div_cnt + 4'h1;
      next_ext_cnt = ext_cnt;
      next_ext_div = ext_div;
      direct_tick  = 1'b0;
      // four source edges per half period gives divide by 8
      if (ext_rise)
      begin
         next_ext_cnt = ext_cnt + 2'h1;
         if (ext_cnt == rtm_pkg::EXT_HALF)
         begin
            next_ext_div = ~ext_div;
            direct_tick  = ~ext_div;
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         div_cnt <= 4'h0;
         ext_q   <= 1'b0;
         ext_cnt <= 2'h0;
         ext_div <= 1'b0;
         sync1   <= 1'b0;
         sync2   <= 1'b0;
         sync3   <= 1'b0;
      end
      else
      begin
         div_cnt <= next_div_cnt;
         ext_q   <= ext_clk;
         ext_cnt <= next_ext_cnt;
         ext_div <= next_ext_div;
         sync1   <= ext_div;
         sync2   <= sync1;
         sync3   <= sync2;
      end
   end

   assign tick_sys12 = (div_cnt == rtm_pkg::SYS_DIV - 4'h1);
   // suspended oscillator: divided wave drives the count without the sync delay
   assign tick_ext   = suspend ? direct_tick : (sync2 & ~sync3);

endmodule

/* rtm_edge.sv */
/*
 * Comparator rising-edge detector with a two-stage synchroniser.
 * Assumes cmp_out may change at any time relative to ref_clk.
 */
`timescale 1ns/1ps
module rtm_edge
(
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_b,
   // comparator
   input  wire logic cmp_out,
   output logic      cmp_rise
);

   logic s1;
   logic s2;
   logic s3;

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end
      else
      begin
         s1 <= cmp_out;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // low sample then high sample, both past the metastable stage
   assign cmp_rise = s2 & ~s3;

endmodule

/* rtm_timer.sv */
/*
 * Reload timer with comparator capture: 16-bit or split dual 8-bit auto-reload,
 * capture of comparator rising edges, suspend-mode wake-up, register port.
 * Assumes a bus master that strobes one cycle and takes read data the next cycle.
 */
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
// Overview of operation
// - Counter is two 8-bit halves; split bit picks 16-bit or dual 8-bit reload.
// - Clock choices: system clock, system clock / 12, external clock / 8.
// - Divided external clock synchronised except in suspend, where it drives directly.
// - Counting continues in suspend; a 16-bit or high-half overflow requests wake-up.
// - Other wake source: busy flag high for three external clock / 8 ticks; software waits.
// - 16-bit wrap from FFFF loads the reload word and sets the high flag.
// - Timer interrupt enable bit 7 raises an interrupt on each 16-bit overflow.
// - In 16-bit mode low-byte enable also interrupts on low byte wrap.
// - Split mode: halves reload independently from their own reload bytes.
// - Split mode: run bit gates only the high half; low half always counts.
// - Split mode: per-half select, 1 system clock, else external-select choice.
// - Split mode: each half's wrap sets its own overflow flag.
// - Split mode: high wrap interrupts, low wrap too when low enable set.
// - Overflow flags are cleared only by software writing zero.
// - Capture (16-bit mode only): comparator rise copies counter to reload and sets high flag.
// - External-select bit: 0 system clock / 12, 1 external clock / 8.
// - Low flag sets on every low half wrap, in any mode.
module rtm_timer
(
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_b,
   // register port
   input  wire logic [2:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // outside sources
   input  wire logic       ext_clk,
   input  wire logic       cmp_out,
   input  wire logic       suspend,
   // status outputs
   output logic            timer_irq,
   output logic            wake_req,
   output logic            sync_busy_flag
);

   rtm_pkg::rtm_ctrl_t ctrl;
   rtm_pkg::rtm_ctrl_t next_ctrl;
   logic [7:0]         cnt_l;
   logic [7:0]         cnt_h;
   logic [7:0]         rl_l;
   logic [7:0]         rl_h;
   logic [7:0]         next_cnt_l;
   logic [7:0]         next_cnt_h;
   logic [7:0]         next_rl_l;
   logic [7:0]         next_rl_h;
   logic [1:0]         clk_sel;
   logic [1:0]         next_clk_sel;
   logic               timer_ie;
   logic               next_timer_ie;
   logic [7:0]         next_rdata;
   logic               next_wake;
   logic               tick_sys12;
   logic               tick_ext;
   logic               cmp_rise;
   logic               tick_l;
   logic               tick_h;
   logic               ov_l;
   logic               ov_h;
   logic               cap_hit;
   logic               set_hi;
   logic               set_lo;
   rtm_pkg::rtm_sync_t sync_st;
   rtm_pkg::rtm_sync_t next_sync_st;
   logic [1:0]         sync_cnt;
   logic [1:0]         next_sync_cnt;
   logic               susp_q;
   logic               woke;
   logic               next_woke;

   // per-half tick: 1 system clock, 0 external-select choice
   function automatic logic tick_pick(input logic sys_sel, input logic ext_sel,
                                      input logic t12, input logic text);
      tick_pick = sys_sel ? 1'b1 : (ext_sel ? text : t12);
   endfunction

   rtm_prescale u_prescale
   (
      .ref_clk    (ref_clk),
      .rst_b      (rst_b),
      .ext_clk    (ext_clk),
      .suspend    (suspend),
      .tick_sys12 (tick_sys12),
      .tick_ext   (tick_ext)
   );

   rtm_edge u_edge
   (
      .ref_clk  (ref_clk),
      .rst_b    (rst_b),
      .cmp_out  (cmp_out),
      .cmp_rise (cmp_rise)
   );

   // 16-bit mode runs on the low half's select
   assign tick_l = tick_pick(clk_sel[rtm_pkg::CLK_LOW_SEL_BIT], ctrl.ext_sel,
                             tick_sys12, tick_ext);
   assign tick_h = tick_pick(clk_sel[rtm_pkg::CLK_HIGH_SEL_BIT], ctrl.ext_sel,
                             tick_sys12, tick_ext);

   always_comb
   begin
      next_cnt_l    = cnt_l;
      next_cnt_h    = cnt_h;
      next_rl_l     = rl_l;
      next_rl_h     = rl_h;
      next_ctrl     = ctrl;
      next_clk_sel  = clk_sel;
      next_timer_ie = timer_ie;
      ov_l          = 1'b0;
      ov_h          = 1'b0;
      cap_hit       = 1'b0;
      if (!ctrl.split)
      begin
         if (ctrl.run && tick_l)
         begin
            ov_l = (cnt_l == rtm_pkg::BYTE_MAX);
            ov_h = ({cnt_h, cnt_l} == rtm_pkg::WORD_MAX);
            if (ov_h)
            begin
               {next_cnt_h, next_cnt_l} = {rl_h, rl_l};
            end
            else
            begin
               {next_cnt_h, next_cnt_l} = {cnt_h, cnt_l} + 16'h0001;
            end
         end
         // capture takes the count as it stands before this cycle's increment
         if (ctrl.cap_en && cmp_rise)
         begin
            cap_hit   = 1'b1;
            next_rl_h = cnt_h;
            next_rl_l = cnt_l;
         end
      end
      else
      begin
         if (tick_l)
         begin
            ov_l       = (cnt_l == rtm_pkg::BYTE_MAX);
            next_cnt_l = ov_l ? rl_l : cnt_l + 8'h01;
         end
         if (ctrl.run && tick_h)
         begin
            ov_h       = (cnt_h == rtm_pkg::BYTE_MAX);
            next_cnt_h = ov_h ? rl_h : cnt_h + 8'h01;
         end
      end
      set_hi = ov_h | cap_hit;
      set_lo = ov_l;
      // software writes win over counting; flag sets win over a clearing write
      if (reg_wr)
      begin
         case (reg_addr)
            rtm_pkg::OFS_CTRL:
            begin
               next_ctrl        = rtm_pkg::rtm_ctrl_t'(reg_wdata);
               next_ctrl.unused = 1'b0;
            end
            rtm_pkg::OFS_RELOAD_LO: next_rl_l = reg_wdata;
            rtm_pkg::OFS_RELOAD_HI: next_rl_h = reg_wdata;
            rtm_pkg::OFS_COUNT_LO:  next_cnt_l = reg_wdata;
            rtm_pkg::OFS_COUNT_HI:  next_cnt_h = reg_wdata;
            rtm_pkg::OFS_CLK_CTRL:  next_clk_sel = reg_wdata[1:0];
            rtm_pkg::OFS_INT_EN:    next_timer_ie = reg_wdata[rtm_pkg::TIMER_IE_BIT];
            default:                next_ctrl = next_ctrl;
         endcase
      end
      next_ctrl.hi_flag = next_ctrl.hi_flag | set_hi;
      next_ctrl.lo_flag = next_ctrl.lo_flag | set_lo;
      next_wake = suspend & ov_h;
      next_rdata = 8'h00;
      if (reg_rd)
      begin
         case (reg_addr)
            rtm_pkg::OFS_CTRL:      next_rdata = ctrl;
            rtm_pkg::OFS_RELOAD_LO: next_rdata = rl_l;
            rtm_pkg::OFS_RELOAD_HI: next_rdata = rl_h;
            rtm_pkg::OFS_COUNT_LO:  next_rdata = cnt_l;
            rtm_pkg::OFS_COUNT_HI:  next_rdata = cnt_h;
            rtm_pkg::OFS_CLK_CTRL:  next_rdata = {6'h00, clk_sel};
            rtm_pkg::OFS_INT_EN:    next_rdata = {timer_ie, 7'h00};
            rtm_pkg::OFS_STATUS:    next_rdata = {7'h00, sync_st == rtm_pkg::SYNC_BUSY};
            default:                next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         ctrl      <= rtm_pkg::rtm_ctrl_t'(rtm_pkg::CTRL_RESET);
         cnt_l     <= rtm_pkg::BYTE_RESET;
         cnt_h     <= rtm_pkg::BYTE_RESET;
         rl_l      <= rtm_pkg::BYTE_RESET;
         rl_h      <= rtm_pkg::BYTE_RESET;
         clk_sel   <= rtm_pkg::CLKSEL_RESET;
         timer_ie  <= 1'b0;
         reg_rdata <= 8'h00;
         wake_req  <= 1'b0;
      end
      else
      begin
         ctrl      <= next_ctrl;
         cnt_l     <= next_cnt_l;
         cnt_h     <= next_cnt_h;
         rl_l      <= next_rl_l;
         rl_h      <= next_rl_h;
         clk_sel   <= next_clk_sel;
         timer_ie  <= next_timer_ie;
         reg_rdata <= next_rdata;
         wake_req  <= next_wake;
      end
   end

   // level from the sticky flags; the cpu finds the source from both flags
   assign timer_irq = timer_ie & (ctrl.hi_flag | (ctrl.lo_ie & ctrl.lo_flag));

   // busy window after a wake that the timer did not cause
   always_comb
   begin
      next_sync_st  = sync_st;
      next_sync_cnt = sync_cnt;
      next_woke     = woke;
      if (next_wake)
      begin
         next_woke = 1'b1;
      end
      case (sync_st)
         rtm_pkg::SYNC_IDLE:
         begin
            if (susp_q && !suspend)
            begin
               next_woke = 1'b0;
               if (!woke)
               begin
                  next_sync_st  = rtm_pkg::SYNC_BUSY;
                  next_sync_cnt = 2'h0;
               end
            end
         end
         rtm_pkg::SYNC_BUSY:
         begin
            if (tick_ext)
            begin
               next_sync_cnt = sync_cnt + 2'h1;
               if (sync_cnt == rtm_pkg::SYNC_TICKS - 2'h1)
               begin
                  next_sync_st = rtm_pkg::SYNC_IDLE;
               end
            end
         end
         default: next_sync_st = rtm_pkg::SYNC_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         sync_st  <= rtm_pkg::SYNC_IDLE;
         sync_cnt <= 2'h0;
         susp_q   <= 1'b0;
         woke     <= 1'b0;
      end
      else
      begin
         sync_st  <= next_sync_st;
         sync_cnt <= next_sync_cnt;
         susp_q   <= suspend;
         woke     <= next_woke;
      end
   end

   assign sync_busy_flag = (sync_st == rtm_pkg::SYNC_BUSY);

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);

   wrap_reload_a: assert property (
      !ctrl.split && ctrl.run && tick_l && {cnt_h, cnt_l} == 16'hFFFF && !reg_wr
      |=> {cnt_h, cnt_l} == $past({rl_h, rl_l}) && ctrl.hi_flag)
      else $error("16-bit wrap did not reload or flag");
   low_flag_a: assert property (
      tick_l && cnt_l == 8'hFF && (ctrl.split || ctrl.run) && !reg_wr |=> ctrl.lo_flag)
      else $error("low wrap did not set low flag");
   split_stop_a: assert property (
      ctrl.split && !ctrl.run && !reg_wr |=> $stable(cnt_h))
      else $error("stopped high half moved");
   split_low_a: assert property (
      ctrl.split && tick_l && cnt_l != 8'hFF && !reg_wr |=> cnt_l == $past(cnt_l) + 8'h01)
      else $error("split low half did not count");
   irq_gate_a: assert property (
      ctrl.hi_flag |-> timer_irq == timer_ie)
      else $error("interrupt does not follow enable");
   flag_sticky_a: assert property (
      ctrl.hi_flag && !(reg_wr && reg_addr == 3'h0) |=> ctrl.hi_flag)
      else $error("high flag cleared by hardware");
   capture_copy_a: assert property (
      ctrl.cap_en && !ctrl.split && cmp_rise && !reg_wr
      |=> {rl_h, rl_l} == $past({cnt_h, cnt_l}) && ctrl.hi_flag)
      else $error("capture did not copy count");
   busy_set_a: assert property (
      sync_st == rtm_pkg::SYNC_IDLE && susp_q && !suspend && !woke |=> sync_busy_flag)
      else $error("busy flag not raised after foreign wake");
   wake_pulse_a: assert property (
      suspend && !ctrl.split && ctrl.run && tick_l && {cnt_h, cnt_l} == 16'hFFFF |=> wake_req)
      else $error("overflow in suspend did not request wake");

endmodule

/* rtm_far_side.sv */
/*
 * Far-side model: external oscillator and comparator output feeding the timer.
 * Assumes the bench starts and stops oscillator bursts and sets the comparator level.
 */
`timescale 1ns/1ps
module rtm_far_side
(
   // control from bench
   input  wire logic ext_en,
   input  wire logic cmp_level,
   // outside sources
   output logic      ext_clk,
   output logic      cmp_out
);
   // free phase against ref_clk; a burst always ends on a full period
   // rises never meet a ref_clk edge, so each one is counted exactly once
   initial ext_clk = 1'b0;
   always
   begin
      if (ext_en)
      begin
         #33 ext_clk = 1'b1;
         #37 ext_clk = 1'b0;
      end
      else
         #5;
   end
   // edges land off the clock grid and far slower than the timer clock
   assign #3 cmp_out = cmp_level;
endmodule

/* testbench.sv */
/*
 * Self-checking bench for the reload timer: register port tasks and mode scenarios.
 * Assumes rtm_pkg, rtm_timer and rtm_far_side are compiled first.
 */
`timescale 1ns/1ps
module testbench;
   logic       ref_clk = 1'b0;
   logic       rst_b = 1'b0;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic       ext_clk;
   logic       cmp_out;
   logic       suspend = 1'b0;
   logic       timer_irq;
   logic       wake_req;
   logic       sync_busy_flag;
   logic       ext_en = 1'b0;
   logic       cmp_level = 1'b0;
   int         n_wake = 0;
   logic [7:0] d;
   int         n_fail = 0;
   int         samples_checked = 0;
   int         cycles = 0;

   rtm_timer uut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_clk(ext_clk), .cmp_out(cmp_out),
      .suspend(suspend), .timer_irq(timer_irq), .wake_req(wake_req), .sync_busy_flag(sync_busy_flag));
   rtm_far_side far (.ext_en(ext_en), .cmp_level(cmp_level), .ext_clk(ext_clk), .cmp_out(cmp_out));

   always #5 ref_clk = ~ref_clk;

   always @(posedge ref_clk)
   begin
      if (wake_req === 1'b1)
         n_wake++;
      cycles++;
      if (cycles == 40000)
      begin
         n_fail++;
         $display("wrong value at %0t: run did not finish in time", $time);
         stop_test();
      end
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: byte %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: bit %b expected %b", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [2:0] a);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic wait_irq(input int lim);
      int i;
      i = 0;
      // the edge that took the last write still shows the old flags
      @(posedge ref_clk);
      while (timer_irq !== 1'b1 && i < lim)
      begin
         @(posedge ref_clk);
         i++;
      end
   endtask

   // bursts are whole periods so the divide-by-8 phase stays known
   task automatic ext_edges(input int n);
      @(posedge ref_clk);
      ext_en <= 1'b1;
      repeat (n) @(posedge ext_clk);
      @(posedge ref_clk);
      ext_en <= 1'b0;
      repeat (10) @(posedge ref_clk);
   endtask

   initial
   begin
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      for (int a = 0; a < 8; a++)
      begin
         rd(3'(a));
         chk8(d, 8'h00);
      end
      // 16-bit wrap reloads and raises the high flag
      wr(rtm_pkg::OFS_CLK_CTRL, 8'h01);
      wr(rtm_pkg::OFS_RELOAD_LO, 8'h34);
      wr(rtm_pkg::OFS_RELOAD_HI, 8'h12);
      wr(rtm_pkg::OFS_COUNT_LO, 8'hF0);
      wr(rtm_pkg::OFS_COUNT_HI, 8'hFF);
      wr(rtm_pkg::OFS_INT_EN, 8'h80);
      wr(rtm_pkg::OFS_CTRL, 8'h04);
      wait_irq(100);
      chk1(timer_irq, 1'b1);
      rd(rtm_pkg::OFS_COUNT_HI);
      chk8(d, 8'h12);
      repeat (20) @(posedge ref_clk);
      rd(rtm_pkg::OFS_CTRL);
      chk1(d[7], 1'b1);
      wr(rtm_pkg::OFS_CTRL, 8'h00);
      rd(rtm_pkg::OFS_CTRL);
      chk8(d, 8'h00);
      chk1(timer_irq, 1'b0);
      // low byte wrap interrupts in 16-bit mode
      wr(rtm_pkg::OFS_COUNT_LO, 8'hF8);
      wr(rtm_pkg::OFS_COUNT_HI, 8'h00);
      wr(rtm_pkg::OFS_CTRL, 8'h24);
      wait_irq(30);
      chk1(timer_irq, 1'b1);
      rd(rtm_pkg::OFS_CTRL);
      chk8(d, 8'h64);
      // split mode, both halves on the system clock, high half stopped
      wr(rtm_pkg::OFS_CTRL, 8'h00);
      wr(rtm_pkg::OFS_CLK_CTRL, 8'h03);
      wr(rtm_pkg::OFS_RELOAD_LO, 8'hF0);
      wr(rtm_pkg::OFS_RELOAD_HI, 8'hE0);
      wr(rtm_pkg::OFS_COUNT_LO, 8'hFE);
      wr(rtm_pkg::OFS_COUNT_HI, 8'h00);
      wr(rtm_pkg::OFS_CTRL, 8'h08);
      repeat (20) @(posedge ref_clk);
      rd(rtm_pkg::OFS_CTRL);
      chk8(d, 8'h48);
      chk1(timer_irq, 1'b0);
      rd(rtm_pkg::OFS_COUNT_HI);
      chk8(d, 8'h00);
      rd(rtm_pkg::OFS_COUNT_LO);
      chk1(d >= 8'hF0, 1'b1);
      wr(rtm_pkg::OFS_COUNT_HI, 8'hFC);
      wr(rtm_pkg::OFS_CTRL, 8'h0C);
      wait_irq(30);
      chk1(timer_irq, 1'b1);
      rd(rtm_pkg::OFS_COUNT_HI);
      chk1(d >= 8'hE0, 1'b1);
      rd(rtm_pkg::OFS_CTRL);
      chk1(d[7], 1'b1);
      wr(rtm_pkg::OFS_CTRL, 8'h28);
      wait_irq(40);
      chk1(timer_irq, 1'b1);
      // split low half on system clock / 12
      wr(rtm_pkg::OFS_CLK_CTRL, 8'h00);
      wr(rtm_pkg::OFS_RELOAD_LO, 8'h00);
      wr(rtm_pkg::OFS_CTRL, 8'h08);
      wr(rtm_pkg::OFS_COUNT_LO, 8'h00);
      repeat (119) @(posedge ref_clk);
      rd(rtm_pkg::OFS_COUNT_LO);
      chk8(d, 8'h0A);
      // split low half on external clock / 8, 16 edges give 2 counts
      wr(rtm_pkg::OFS_CTRL, 8'h09);
      wr(rtm_pkg::OFS_COUNT_LO, 8'h00);
      ext_edges(16);
      rd(rtm_pkg::OFS_COUNT_LO);
      chk8(d, 8'h02);
      // suspend: external clock drives the counter and overflow wakes
      wr(rtm_pkg::OFS_COUNT_LO, 8'hFE);
      wr(rtm_pkg::OFS_COUNT_HI, 8'hFF);
      wr(rtm_pkg::OFS_CTRL, 8'h05);
      suspend <= 1'b1;
      ext_edges(16);
      chk1(n_wake == 1, 1'b1);
      suspend <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk1(sync_busy_flag, 1'b0);
      // foreign wake: busy until three external ticks
      wr(rtm_pkg::OFS_CTRL, 8'h00);
      suspend <= 1'b1;
      repeat (5) @(posedge ref_clk);
      suspend <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk1(sync_busy_flag, 1'b1);
      ext_edges(24);
      chk1(sync_busy_flag, 1'b0);
      rd(rtm_pkg::OFS_STATUS);
      chk8(d, 8'h00);
      // capture of a comparator rise; slow edge, fast timer clock
      wr(rtm_pkg::OFS_CLK_CTRL, 8'h01);
      wr(rtm_pkg::OFS_COUNT_LO, 8'h00);
      wr(rtm_pkg::OFS_COUNT_HI, 8'h01);
      wr(rtm_pkg::OFS_CTRL, 8'h14);
      repeat (10) @(posedge ref_clk);
      cmp_level <= 1'b1;
      wait_irq(20);
      chk1(timer_irq, 1'b1);
      rd(rtm_pkg::OFS_RELOAD_HI);
      chk8(d, 8'h01);
      rd(rtm_pkg::OFS_RELOAD_LO);
      chk8(d, 8'h0C);
      rd(rtm_pkg::OFS_CTRL);
      chk8(d, 8'h94);
      cmp_level <= 1'b0;
      repeat (5) @(posedge ref_clk);
      stop_test();
   end
endmodule
